// [testbench/clamp_alc_stripper_regs_bench.sv]
// self-checking bench for the clamp register bank
`timescale 1ns/1ps
`default_nettype none
module clamp_alc_stripper_regs_bench import clamp_cfg_pkg::*;;
	localparam logic [7:0] RV [9] = '{RST_ADC_BIAS_SETUP,
		RST_COARSE_CLAMP_CONTROL, RST_GREEN_SYNC_CLAMP_CONTROL,
		RST_RGB_CLAMP_LEAKAGE, RST_GREEN_SYNC_CLAMP_LEAKAGE,
		RST_LEVEL_CONTROL_PLACEMENT, RST_PSEUDO_SYNC_THRESHOLD,
		RST_SHORT_PULSE_THRESHOLD, RST_SYNC_MASK_WINDOW_WIDTH};
	logic clk, resetn, lvl_trailing_ref, mask_en, ref_tick, hsync_in;
	logic short_pulse, normal_pulse, rd_pend;
	logic [1:0] fine_clamp_req;
	logic [8:0] exp_v;
	logic [8:0] exp_q [$];
	wire logic reg_wr_en, reg_rd_en, reg_rd_hit, green_sync_clamp_en;
	wire logic auto_level_control, sync_mask, sync_proc_reset;
	wire logic [7:0] reg_addr, reg_wr_data, reg_rd_data, pseudo_sync_thr;
	wire logic [3:0] adc_bias, bias_step_code;
	wire logic [5:0] bias_current, rgb_leak_code, green_sync_leak_code;
	wire logic [1:0] rgb_charge_current_sel, fine_clamp_en;
	wire logic [1:0] green_sync_charge_current_sel;
	wire logic [2:0] coarse_clamp_en;
	wire logic [15:0] rgb_droop_current, green_sync_droop_current;
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	reg_host host_u (.clk, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data);
	clamp_alc_stripper_regs dut_u (.clk, .resetn, .reg_wr_en, .reg_rd_en,
		.reg_addr, .reg_wr_data, .reg_rd_data, .reg_rd_hit, .lvl_trailing_ref,
		.mask_en, .fine_clamp_req, .ref_tick, .hsync_in, .short_pulse,
		.normal_pulse, .adc_bias, .bias_step_code, .bias_current,
		.rgb_charge_current_sel, .coarse_clamp_en, .fine_clamp_en,
		.green_sync_clamp_en, .green_sync_charge_current_sel, .rgb_leak_code,
		.green_sync_leak_code, .rgb_droop_current, .green_sync_droop_current,
		.pseudo_sync_thr, .auto_level_control, .sync_mask, .sync_proc_reset);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask
	task close_out;
		if (n_errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_u.acc(1'b1, a, d);
	endtask
	task automatic rdx(input logic [7:0] a, input logic [7:0] e, input logic h);
		exp_q.push_back({h, e});
		host_u.acc(1'b0, a, 8'h00);
	endtask
	task automatic lvl(input logic [7:0] n, input logic tr);
		int c;
		wr(ADDR_LEVEL_CONTROL_PLACEMENT, n);
		lvl_trailing_ref = tr;
		hsync_in = tr;
		repeat (270) @(posedge clk);
		#1 hsync_in = !tr;
		c = 0;
		while (auto_level_control !== 1'b1 && c < 300) begin
			@(negedge clk);
			c++;
		end
		chk(c, n + 3);
	endtask
	task automatic mask_run(input logic en, input logic [7:0] w);
		int m;
		wr(ADDR_SYNC_MASK_WINDOW_WIDTH, w);
		mask_en = en;
		hsync_in = 1'b0;
		repeat (4) @(posedge clk);
		#1 hsync_in = 1'b1;
		m = 0;
		repeat (600) begin
			@(negedge clk);
			if (sync_mask === 1'b1)
				m++;
		end
		// ref ticks every second clock: window lasts 2 * 2 * width clocks
		chk(en ? (m >= 4 * w - 1 && m <= 4 * w) : m == 0, 1);
	endtask
	task automatic pulse(input logic s);
		@(posedge clk);
		#1;
		short_pulse = s;
		normal_pulse = !s;
		@(posedge clk);
		#1;
		short_pulse = 1'b0;
		normal_pulse = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		ref_tick = 1'b0;
		forever begin
			@(posedge clk);
			#1 ref_tick = !ref_tick;
		end
	end
	always @(posedge clk) begin
		cyc++;
		rd_pend <= reg_rd_en;
		if (cyc == 20000) begin
			n_errors++;
			$display("ERROR %0t timeout", $time);
			close_out();
		end
	end
	always @(negedge clk) begin
		if (rd_pend === 1'b1) begin
			exp_v = exp_q.pop_front();
			chk({7'h00, reg_rd_hit, reg_rd_data}, {7'h00, exp_v});
		end
	end
	initial begin
		logic [7:0] v [9];
		int k;
		{resetn, mask_en, hsync_in, short_pulse, normal_pulse} = 5'h00;
		{lvl_trailing_ref, fine_clamp_req} = 3'h7;
		void'($urandom(32'h5790));
		repeat (6) @(posedge clk);
		#1 resetn = 1'b1;
		repeat (2) @(negedge clk);
		chk(adc_bias, 4'h5);
		chk(green_sync_clamp_en, 1'b1);
		chk(pseudo_sync_thr, 8'h18);
		chk(fine_clamp_en, 2'h3);
		for (k = 0; k < 9; k++)
			rdx(8'(8'h2C + k), RV[k], 1'b1);
		wr(8'h35, 8'hFF);
		rdx(8'h2B, 8'h00, 1'b0);
		rdx(8'h35, 8'h00, 1'b0);
		for (k = 0; k < 9; k++)
			v[k] = 8'($urandom);
		v[5] = 8'h18;
		v[6] = 8'h18;
		v[7] = 8'h60;
		v[1][5:3] = 3'h0;
		v[2][4:0] = 5'h00;
		v[3][7:6] = RST_RGB_CLAMP_LEAKAGE[7:6];
		v[4][7:6] = RST_GREEN_SYNC_CLAMP_LEAKAGE[7:6];
		for (k = 0; k < 9; k++)
			wr(8'(8'h2C + k), v[k]);
		for (k = 0; k < 9; k++)
			rdx(8'(8'h2C + k), v[k], 1'b1);
		chk({adc_bias, bias_step_code}, v[0]);
		chk(bias_current, 6'h02 + {1'b0, v[0][3:0], 1'b0});
		chk({rgb_charge_current_sel, coarse_clamp_en}, {v[1][7:6], v[1][2:0]});
		chk({green_sync_clamp_en, green_sync_charge_current_sel}, v[2][7:5]);
		chk({rgb_leak_code, green_sync_leak_code}, {v[3][5:0], v[4][5:0]});
		chk(rgb_droop_current,
			16'h32 + 16'h32 * (v[0][3:0] + 1) * v[3][5:0]);
		chk(green_sync_droop_current,
			16'h01 + 16'h05 * (v[0][3:0] + 1) * v[4][5:0]);
		chk(pseudo_sync_thr, v[6]);
		for (k = 0; k < 4; k++) begin
			wr(ADDR_COARSE_CLAMP_CONTROL, k == 3 ? 8'h00 : 8'(1 << k));
			repeat (3) @(negedge clk);
			chk(fine_clamp_en, k == 3 ? 2'h3 : 2'h0);
		end
		lvl(8'h00, 1'b0);
		lvl(8'h18, 1'b1);
		lvl(8'h5A, 1'b0);
		lvl(8'($urandom_range(1, 255)), 1'b1);
		mask_run(1'b1, 8'($urandom_range(1, 40)));
		mask_run(1'b0, 8'h24);
		for (k = 1; k <= 200; k++) begin
			pulse(k != 150);
			chk(sync_proc_reset, k == 97);
		end
		repeat (4) @(posedge clk);
		close_out();
	end
endmodule
`default_nettype wire

// [testbench/clamp_regs_checker_properties.sv]
// port-level checker for the clamp register bank
`timescale 1ns/1ps
`default_nettype none
module clamp_regs_checker (
	input wire logic clk,
	input wire logic resetn,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wr_data,
	input wire logic [7:0] reg_rd_data,
	input wire logic reg_rd_hit,
	input wire logic lvl_trailing_ref,
	input wire logic mask_en,
	input wire logic hsync_in,
	input wire logic short_pulse,
	input wire logic [3:0] bias_step_code,
	input wire logic [5:0] bias_current,
	input wire logic [2:0] coarse_clamp_en,
	input wire logic [1:0] fine_clamp_en,
	input wire logic [5:0] rgb_leak_code,
	input wire logic [5:0] green_sync_leak_code,
	input wire logic [15:0] rgb_droop_current,
	input wire logic [15:0] green_sync_droop_current,
	input wire logic auto_level_control,
	input wire logic sync_mask,
	input wire logic sync_proc_reset
);
	logic [7:0] n_r;
	logic [8:0] cnt_r;
	logic busy_r;
	logic hs_r;
	wire mapped = reg_addr >= 8'h2C && reg_addr <= 8'h34;
	wire fell_w = hs_r && !hsync_in;
	wire rose_w = !hs_r && hsync_in;
	wire edge_sel = lvl_trailing_ref ? fell_w : rose_w;
	////////////////////////////////////////////////////////////////////////
	// track placement count and cycles since the selected edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			n_r <= 8'h5A;
			busy_r <= 1'b0;
			cnt_r <= 9'h000;
			hs_r <= 1'b0;
		end else begin
			hs_r <= hsync_in;
			if (reg_wr_en && reg_addr == 8'h31)
				n_r <= reg_wr_data;
			if (edge_sel && !busy_r) begin
				busy_r <= 1'b1;
				cnt_r <= 9'h000;
			end else if (busy_r)
				cnt_r <= cnt_r + 9'h001;
			if (auto_level_control)
				busy_r <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_coarse_wr;
		reg_wr_en && reg_addr == 8'h2D;
	endsequence
	property p_unmapped_rd;
		reg_rd_en && !mapped |=> reg_rd_data == 8'h00 && !reg_rd_hit;
	endproperty
	property p_mapped_rd;
		reg_rd_en && mapped |=> reg_rd_hit;
	endproperty
	property p_coarse_field;
		logic [2:0] d;
		(s_coarse_wr, d = reg_wr_data[2:0]) |-> ##2 coarse_clamp_en == d;
	endproperty
	property p_fine_off;
		coarse_clamp_en != 3'h0 && $past(coarse_clamp_en) != 3'h0
			|-> fine_clamp_en == 2'h0;
	endproperty
	property p_bias;
		bias_current == 6'h02 + {1'b0, bias_step_code, 1'b0};
	endproperty
	property p_rgb_droop;
		$past(resetn) |-> rgb_droop_current == 16'h0032 + 16'h0032
			* ({12'h000, bias_step_code} + 16'h0001) * {10'h000, rgb_leak_code};
	endproperty
	property p_sync_droop;
		$past(resetn) |-> green_sync_droop_current == 16'h0001 + 16'h0005
			* ({12'h000, bias_step_code} + 16'h0001)
			* {10'h000, green_sync_leak_code};
	endproperty
	property p_lvl_place;
		auto_level_control |-> busy_r && cnt_r == {1'b0, n_r} + 9'h001;
	endproperty
	property p_short_rst;
		sync_proc_reset |-> $past(short_pulse);
	endproperty
	property p_mask_off;
		!$past(mask_en) |-> !sync_mask;
	endproperty
	a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read");
	a_mapped_rd: assert property (p_mapped_rd) else $error("read hit missing");
	a_coarse_field: assert property (p_coarse_field) else $error("coarse field");
	a_fine_off: assert property (p_fine_off) else $error("fine not overridden");
	a_bias: assert property (p_bias) else $error("bias current");
	a_rgb_droop: assert property (p_rgb_droop) else $error("rgb droop");
	a_sync_droop: assert property (p_sync_droop) else $error("sync droop");
	a_lvl_place: assert property (p_lvl_place) else $error("level pulse");
	a_short_rst: assert property (p_short_rst) else $error("sync reset");
	a_mask_off: assert property (p_mask_off) else $error("mask while off");
endmodule
bind clamp_alc_stripper_regs clamp_regs_checker chk_u (.clk, .resetn,
	.reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data,
	.reg_rd_hit, .lvl_trailing_ref, .mask_en, .hsync_in, .short_pulse,
	.bias_step_code, .bias_current, .coarse_clamp_en, .fine_clamp_en,
	.rgb_leak_code, .green_sync_leak_code, .rgb_droop_current,
	.green_sync_droop_current, .auto_level_control, .sync_mask,
	.sync_proc_reset);
`default_nettype wire

// [testbench/reg_host.sv]
// host model driving the subaddress register port
`timescale 1ns/1ps
`default_nettype none
module reg_host (
	input wire logic clk,
	output logic reg_wr_en,
	output logic reg_rd_en,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wr_data
);
	initial begin
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = 8'h00;
		reg_wr_data = 8'h00;
	end
	// one access held over one taken edge; released lines show inverse
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		reg_wr_en = w;
		reg_rd_en = !w;
		reg_addr = a;
		reg_wr_data = d;
		@(posedge clk);
		#1;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = ~a;
		reg_wr_data = ~d;
	endtask
endmodule
`default_nettype wire

// [verilog/clamp_alc_stripper_regs.sv]
// clamp, level-control placement and sync-mask register bank
`timescale 1ns/1ps
`default_nettype none
module clamp_alc_stripper_regs
	import clamp_cfg_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wr_data,
	output logic [7:0] reg_rd_data,
	output logic reg_rd_hit,
	input wire logic lvl_trailing_ref,
	input wire logic mask_en,
	input wire logic [1:0] fine_clamp_req,
	input wire logic ref_tick,
	input wire logic hsync_in,
	input wire logic short_pulse,
	input wire logic normal_pulse,
	output logic [3:0] adc_bias,
	output logic [3:0] bias_step_code,
	output logic [5:0] bias_current,
	output logic [1:0] rgb_charge_current_sel,
	output logic [2:0] coarse_clamp_en,
	output logic [1:0] fine_clamp_en,
	output logic green_sync_clamp_en,
	output logic [1:0] green_sync_charge_current_sel,
	output logic [5:0] rgb_leak_code,
	output logic [5:0] green_sync_leak_code,
	output logic [15:0] rgb_droop_current,
	output logic [15:0] green_sync_droop_current,
	output logic [7:0] pseudo_sync_thr,
	output logic auto_level_control,
	output logic sync_mask,
	output logic sync_proc_reset
);
	////////////////////////////////////////////////////////////////////////
	// register storage
	logic [7:0] adc_bias_setup_r;
	logic [7:0] coarse_clamp_control_r;
	logic [7:0] green_sync_clamp_control_r;
	logic [7:0] rgb_clamp_leakage_r;
	logic [7:0] green_sync_clamp_leakage_r;
	logic [7:0] level_control_placement_r;
	logic [7:0] pseudo_sync_threshold_r;
	logic [7:0] short_pulse_threshold_r;
	logic [7:0] sync_mask_window_width_r;

	wire sel_adc = (reg_addr == ADDR_ADC_BIAS_SETUP);
	wire sel_coarse = (reg_addr == ADDR_COARSE_CLAMP_CONTROL);
	wire sel_gclamp = (reg_addr == ADDR_GREEN_SYNC_CLAMP_CONTROL);
	wire sel_rleak = (reg_addr == ADDR_RGB_CLAMP_LEAKAGE);
	wire sel_gleak = (reg_addr == ADDR_GREEN_SYNC_CLAMP_LEAKAGE);
	wire sel_place = (reg_addr == ADDR_LEVEL_CONTROL_PLACEMENT);
	wire sel_pseudo = (reg_addr == ADDR_PSEUDO_SYNC_THRESHOLD);
	wire sel_short = (reg_addr == ADDR_SHORT_PULSE_THRESHOLD);
	wire sel_width = (reg_addr == ADDR_SYNC_MASK_WINDOW_WIDTH);
	wire sel_any = sel_adc | sel_coarse | sel_gclamp | sel_rleak |
		sel_gleak | sel_place | sel_pseudo | sel_short | sel_width;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			adc_bias_setup_r <= RST_ADC_BIAS_SETUP;
			coarse_clamp_control_r <= RST_COARSE_CLAMP_CONTROL;
			green_sync_clamp_control_r <= RST_GREEN_SYNC_CLAMP_CONTROL;
			rgb_clamp_leakage_r <= RST_RGB_CLAMP_LEAKAGE;
			green_sync_clamp_leakage_r <= RST_GREEN_SYNC_CLAMP_LEAKAGE;
			level_control_placement_r <= RST_LEVEL_CONTROL_PLACEMENT;
			pseudo_sync_threshold_r <= RST_PSEUDO_SYNC_THRESHOLD;
			short_pulse_threshold_r <= RST_SHORT_PULSE_THRESHOLD;
			sync_mask_window_width_r <= RST_SYNC_MASK_WINDOW_WIDTH;
		end else if (reg_wr_en) begin
			if (sel_adc) begin
				adc_bias_setup_r <= reg_wr_data;
			end else if (sel_coarse) begin
				coarse_clamp_control_r <= reg_wr_data;
			end else if (sel_gclamp) begin
				green_sync_clamp_control_r <= reg_wr_data;
			end else if (sel_rleak) begin
				rgb_clamp_leakage_r <= reg_wr_data;
			end else if (sel_gleak) begin
				green_sync_clamp_leakage_r <= reg_wr_data;
			end else if (sel_place) begin
				level_control_placement_r <= reg_wr_data;
			end else if (sel_pseudo) begin
				pseudo_sync_threshold_r <= reg_wr_data;
			end else if (sel_short) begin
				short_pulse_threshold_r <= reg_wr_data;
			end else if (sel_width) begin
				sync_mask_window_width_r <= reg_wr_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read back
	wire [7:0] rd_mux =
		sel_adc ? adc_bias_setup_r :
		sel_coarse ? coarse_clamp_control_r :
		sel_gclamp ? green_sync_clamp_control_r :
		sel_rleak ? rgb_clamp_leakage_r :
		sel_gleak ? green_sync_clamp_leakage_r :
		sel_place ? level_control_placement_r :
		sel_pseudo ? pseudo_sync_threshold_r :
		sel_short ? short_pulse_threshold_r :
		sel_width ? sync_mask_window_width_r : 8'h00;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rd_data <= 8'h00;
			reg_rd_hit <= 1'b0;
		end else if (reg_rd_en) begin
			reg_rd_data <= rd_mux;
			reg_rd_hit <= sel_any;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// field decode
	wire [3:0] step_code = adc_bias_setup_r[BIAS_STEP_LSB +: 4];
	wire [2:0] coarse_en = {coarse_clamp_control_r[COARSE_BLUE_BIT],
		coarse_clamp_control_r[COARSE_GREEN_BIT],
		coarse_clamp_control_r[COARSE_RED_BIT]};
	// bias current in whole uA: 2 + 2 * code
	wire [5:0] bias_ua = {1'b0, step_code, 1'b0} + 6'h02;
	wire [15:0] bias_half = {11'h000, {1'b0, step_code} + 5'h01};
	wire [5:0] rleak = rgb_clamp_leakage_r[LEAK_CODE_LSB +: 6];
	wire [5:0] gleak = green_sync_clamp_leakage_r[LEAK_CODE_LSB +: 6];
	// 0.5 + (bias/4) * n, counted in 0.01 uA
	wire [15:0] rgb_droop = RGB_DROOP_BASE +
		16'(RGB_DROOP_STEP * bias_half * {10'h000, rleak});
	// 0.01 + (bias/40) * n, counted in 0.01 uA
	wire [15:0] sync_droop = SYNC_DROOP_BASE +
		16'(SYNC_DROOP_STEP * bias_half * {10'h000, gleak});
	// any coarse clamp overrides the fine clamp enables
	wire [1:0] fine_eff = (coarse_en != 3'b000) ? 2'b00 : fine_clamp_req;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			adc_bias <= RST_ADC_BIAS_SETUP[ADC_BIAS_LSB +: 4];
			bias_step_code <= RST_ADC_BIAS_SETUP[BIAS_STEP_LSB +: 4];
			bias_current <= 6'h02;
			rgb_charge_current_sel <= 2'b00;
			coarse_clamp_en <= 3'b000;
			fine_clamp_en <= 2'b00;
			green_sync_clamp_en <= 1'b1;
			green_sync_charge_current_sel <= 2'b00;
			rgb_leak_code <= 6'h00;
			green_sync_leak_code <= 6'h00;
			rgb_droop_current <= 16'h0000;
			green_sync_droop_current <= 16'h0000;
			pseudo_sync_thr <= RST_PSEUDO_SYNC_THRESHOLD;
		end else begin
			adc_bias <= adc_bias_setup_r[ADC_BIAS_LSB +: 4];
			bias_step_code <= step_code;
			bias_current <= bias_ua;
			rgb_charge_current_sel <=
				coarse_clamp_control_r[RGB_CHARGE_LSB +: 2];
			coarse_clamp_en <= coarse_en;
			fine_clamp_en <= fine_eff;
			green_sync_clamp_en <=
				green_sync_clamp_control_r[GREEN_SYNC_EN_BIT];
			green_sync_charge_current_sel <=
				green_sync_clamp_control_r[GREEN_SYNC_CHARGE_LSB +: 2];
			rgb_leak_code <= rleak;
			green_sync_leak_code <= gleak;
			rgb_droop_current <= rgb_droop;
			green_sync_droop_current <= sync_droop;
			pseudo_sync_thr <= pseudo_sync_threshold_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sync side helpers
	sync_cfg_if cfg ();

	assign cfg.lvl_delay = level_control_placement_r;
	assign cfg.lvl_trailing_ref = lvl_trailing_ref;
	assign cfg.mask_width = sync_mask_window_width_r;
	assign cfg.mask_en = mask_en;
	assign cfg.short_thr = short_pulse_threshold_r;

	logic hsync_d_r;
	wire hsync_lead = hsync_in & ~hsync_d_r;
	wire hsync_trail = ~hsync_in & hsync_d_r;
	wire lvl_pulse;
	wire mask_active;
	wire sync_rst;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hsync_d_r <= 1'b0;
		end else begin
			hsync_d_r <= hsync_in;
		end
	end

	level_ctrl_timer u_lvl (
		.clk(clk),
		.resetn(resetn),
		.cfg(cfg.lvl),
		.hsync_lead(hsync_lead),
		.hsync_trail(hsync_trail),
		.lvl_pulse(lvl_pulse)
	);

	sync_guard u_guard (
		.clk(clk),
		.resetn(resetn),
		.cfg(cfg.guard),
		.ref_tick(ref_tick),
		.hsync_lead(hsync_lead),
		.short_pulse(short_pulse),
		.normal_pulse(normal_pulse),
		.mask_active(mask_active),
		.sync_reset(sync_rst)
	);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			auto_level_control <= 1'b0;
			sync_mask <= 1'b0;
			sync_proc_reset <= 1'b0;
		end else begin
			auto_level_control <= lvl_pulse;
			sync_mask <= mask_active;
			sync_proc_reset <= sync_rst;
		end
	end
endmodule
`default_nettype wire

// [verilog/clamp_cfg_pkg.sv]
// constants for the clamp, level-control and sync-mask register bank
`default_nettype none
package clamp_cfg_pkg;
	// register subaddresses
	localparam logic [7:0] ADDR_ADC_BIAS_SETUP = 8'h2C;
	localparam logic [7:0] ADDR_COARSE_CLAMP_CONTROL = 8'h2D;
	localparam logic [7:0] ADDR_GREEN_SYNC_CLAMP_CONTROL = 8'h2E;
	localparam logic [7:0] ADDR_RGB_CLAMP_LEAKAGE = 8'h2F;
	localparam logic [7:0] ADDR_GREEN_SYNC_CLAMP_LEAKAGE = 8'h30;
	localparam logic [7:0] ADDR_LEVEL_CONTROL_PLACEMENT = 8'h31;
	localparam logic [7:0] ADDR_PSEUDO_SYNC_THRESHOLD = 8'h32;
	localparam logic [7:0] ADDR_SHORT_PULSE_THRESHOLD = 8'h33;
	localparam logic [7:0] ADDR_SYNC_MASK_WINDOW_WIDTH = 8'h34;

	// reset values
	localparam logic [7:0] RST_ADC_BIAS_SETUP = 8'h50;
	localparam logic [7:0] RST_COARSE_CLAMP_CONTROL = 8'h00;
	localparam logic [7:0] RST_GREEN_SYNC_CLAMP_CONTROL = 8'h80;
	localparam logic [7:0] RST_RGB_CLAMP_LEAKAGE = 8'h8C;
	localparam logic [7:0] RST_GREEN_SYNC_CLAMP_LEAKAGE = 8'h04;
	localparam logic [7:0] RST_LEVEL_CONTROL_PLACEMENT = 8'h5A;
	localparam logic [7:0] RST_PSEUDO_SYNC_THRESHOLD = 8'h18;
	localparam logic [7:0] RST_SHORT_PULSE_THRESHOLD = 8'h60;
	localparam logic [7:0] RST_SYNC_MASK_WINDOW_WIDTH = 8'h03;

	// field positions
	localparam int ADC_BIAS_LSB = 4;
	localparam int BIAS_STEP_LSB = 0;
	localparam int RGB_CHARGE_LSB = 6;
	localparam int COARSE_BLUE_BIT = 2;
	localparam int COARSE_GREEN_BIT = 1;
	localparam int COARSE_RED_BIT = 0;
	localparam int GREEN_SYNC_EN_BIT = 7;
	localparam int GREEN_SYNC_CHARGE_LSB = 5;
	localparam int LEAK_CODE_LSB = 0;

	// bias current 2 uA + 2 uA per step, droop currents in 0.01 uA
	localparam logic [15:0] RGB_DROOP_BASE = 16'h0032;
	localparam logic [15:0] RGB_DROOP_STEP = 16'h0032;
	localparam logic [15:0] SYNC_DROOP_BASE = 16'h0001;
	localparam logic [15:0] SYNC_DROOP_STEP = 16'h0005;

	// mask window spans twice the width setting in reference ticks
	localparam int MASK_WINDOW_FACTOR = 2;

	typedef enum logic [1:0] {
		LVL_IDLE = 2'b00,
		LVL_COUNT = 2'b01,
		LVL_FIRE = 2'b11
	} lvl_state_e;
endpackage
`default_nettype wire

// [verilog/level_ctrl_timer.sv]
// places the level-control pulse a set count after an hsync edge
`timescale 1ns/1ps
`default_nettype none
module level_ctrl_timer
	import clamp_cfg_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	sync_cfg_if.lvl cfg,
	input wire logic hsync_lead,
	input wire logic hsync_trail,
	output logic lvl_pulse
);
	lvl_state_e state_r;
	lvl_state_e state_nxt;
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	wire ref_edge = cfg.lvl_trailing_ref ? hsync_trail : hsync_lead;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		case (state_r)
			LVL_IDLE: begin
				if (ref_edge) begin
					cnt_nxt = cfg.lvl_delay;
					state_nxt = (cfg.lvl_delay == 8'h00) ? LVL_FIRE : LVL_COUNT;
				end
			end
			LVL_COUNT: begin
				cnt_nxt = cnt_r - 8'h01;
				if (cnt_r == 8'h01) begin
					state_nxt = LVL_FIRE;
				end
			end
			default: begin
				state_nxt = LVL_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= LVL_IDLE;
			cnt_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// whole clock periods after the chosen edge
	assign lvl_pulse = (state_r == LVL_FIRE);
endmodule
`default_nettype wire

// [verilog/sync_cfg_if.sv]
// configuration carried from the register bank to the sync helpers
`timescale 1ns/1ps
`default_nettype none
interface sync_cfg_if;
	logic [7:0] lvl_delay;
	logic lvl_trailing_ref;
	logic [7:0] mask_width;
	logic mask_en;
	logic [7:0] short_thr;

	modport bank (output lvl_delay, lvl_trailing_ref, mask_width, mask_en,
		short_thr);
	modport lvl (input lvl_delay, lvl_trailing_ref);
	modport guard (input mask_width, mask_en, short_thr);
endinterface
`default_nettype wire

// [verilog/sync_guard.sv]
// sync mask window and short-pulse run counter
`timescale 1ns/1ps
`default_nettype none
module sync_guard
	import clamp_cfg_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	sync_cfg_if.guard cfg,
	input wire logic ref_tick,
	input wire logic hsync_lead,
	input wire logic short_pulse,
	input wire logic normal_pulse,
	output logic mask_active,
	output logic sync_reset
);
	logic [8:0] win_r;
	logic [8:0] win_nxt;
	logic [7:0] run_r;
	logic [7:0] run_nxt;
	wire [8:0] win_len = {cfg.mask_width, 1'b0};
	wire run_over = short_pulse && (run_r >= cfg.short_thr);

	assign win_nxt = !cfg.mask_en ? 9'h000 :
		hsync_lead ? win_len :
		(ref_tick && win_r != 9'h000) ? win_r - 9'h001 : win_r;
	assign run_nxt = (run_over || normal_pulse) ? 8'h00 :
		(short_pulse && run_r != 8'hFF) ? run_r + 8'h01 : run_r;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			win_r <= 9'h000;
			run_r <= 8'h00;
		end else begin
			win_r <= win_nxt;
			run_r <= run_nxt;
		end
	end

	assign mask_active = cfg.mask_en && (win_r != 9'h000);
	assign sync_reset = run_over;
endmodule
`default_nettype wire
